// file: verilog/odl_device.sv
// Device end of the one-wire dimming link: bit decoder, level register and acknowledge.
//
// Overview of operation
// - Both bytes travel most significant bit first.
// - Host idles line high before each byte.
// - Host may skip start if line already high.
// - Low end-of-stream closes every byte.
// - Bit framed falling edge to falling edge.
// - Decode by twofold high/low time ratio.
// - Data bit seven requests an acknowledge.
// - Acknowledge needs request, address match, sixteen good bits.
// - Pull low after validation delay, bounded time.
// - Acknowledge open drain; host supplies pull-up.
// - Host holds line low during validation.
// - Host releases, samples, low means acknowledged.
// - Host waits for acknowledge end.
// - Only open-drain hosts request acknowledge.
// - Push-pull host should add series resistor.
// - Data byte: request, sub-address, level code.
// - Valid command stores five-bit level code.
// - Level resets to full scale step.
// - Decoding needs no configured bit rate.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module odl_device #(
  parameter logic [7:0] DEV_ADDR = odl_pkg::DEV_ADDR_DEF,
  parameter logic [1:0] SUB_ADDR = odl_pkg::SUB_ADDR_DEF,
  parameter int CNT_W = 18,
  parameter int TMR_W = 17,
  parameter int ACK_CYC = odl_pkg::ACK_CYC,
  parameter int TIMEOUT_CYC = odl_pkg::TIMEOUT_CYC,
  parameter int VALACK_CYC = odl_pkg::VALACK_CYC,
  parameter int EOS_CYC = odl_pkg::EOS_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  odl_link_if.dev link,
  output logic [4:0] level_code,
  output logic [7:0] fb_ref_mv,
  output logic frame_ok,
  output logic frame_err,
  output logic ack_active
);
  localparam logic [CNT_W-1:0] EOS_C = CNT_W'(EOS_CYC);
  localparam logic [CNT_W-1:0] TIMEOUT_C = CNT_W'(TIMEOUT_CYC);
  localparam logic [TMR_W-1:0] VALACK_LAST = TMR_W'(VALACK_CYC - 1);
  localparam logic [TMR_W-1:0] ACK_LAST = TMR_W'(ACK_CYC - 1);
  // The sample that shows a falling edge is itself low, so a frame's low count starts at one.
  // Starting at zero would turn an end-of-stream of exactly the minimum length into a bad byte.
  localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

  // Feedback reference in millivolts for each of the 32 level steps.
  localparam logic [7:0] MV_TABLE [32] = '{
    8'h00, 8'h05, 8'h08, 8'h0b, 8'h0e, 8'h11, 8'h14, 8'h17,
    8'h1a, 8'h1d, 8'h20, 8'h23, 8'h26, 8'h2c, 8'h32, 8'h38,
    8'h3e, 8'h44, 8'h4a, 8'h50, 8'h56, 8'h5c, 8'h62, 8'h68,
    8'h74, 8'h80, 8'h8c, 8'h98, 8'ha4, 8'hb0, 8'hbc, 8'hc8
  };

  generate
    if (ACK_CYC < 1 || ACK_CYC >= (1 << TMR_W) || VALACK_CYC < 1 || VALACK_CYC >= (1 << TMR_W))
    begin : g_bad_tmr
      $error("odl_device: timer width too small for acknowledge timing");
    end
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << CNT_W) || EOS_CYC >= (1 << CNT_W))
    begin : g_bad_cnt
      $error("odl_device: counter width too small for line timing");
    end
  endgenerate

  typedef struct packed {
    odl_pkg::odl_dev_state_t st;
    logic prev;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic [4:0] nbits;
    logic [15:0] shreg;
    logic bad;
    logic [TMR_W-1:0] tmr;
    logic [4:0] level;
    logic [7:0] mv;
    logic ok_p;
    logic err_p;
    logic pull;
  } odl_dev_regs_t;

  odl_dev_regs_t r_reg;
  odl_dev_regs_t r_next;
  logic line_s;
  logic fall;
  logic rise;
  logic good;
  logic abort;
  logic [1:0] dec;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Returns {valid, value}. Only ratios are compared, so no bit rate is configured.
  function automatic logic [1:0] bit_decode(input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
    logic is_one;
    logic is_zero;
    is_one = {1'b0, hi} >= {lo, 1'b0};
    is_zero = {1'b0, lo} >= {hi, 1'b0};
    bit_decode = {is_one | is_zero, is_one};
  endfunction

  odl_sync #(
    .RST_VAL(1'b1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.dim_line),
    .q(line_s)
  );

  assign fall = r_reg.prev & ~line_s;
  assign rise = ~r_reg.prev & line_s;
  assign dec = bit_decode(r_reg.low_cnt, r_reg.high_cnt);
  assign good = ~r_reg.bad & (r_reg.shreg[15:8] == DEV_ADDR)
    & (r_reg.shreg[odl_pkg::SUB_HI_POS:odl_pkg::SUB_LO_POS] == SUB_ADDR);
  // A host that leaves the line high mid-frame has given up; drop the partial frame.
  assign abort = (r_reg.st == odl_pkg::DEV_GAP || r_reg.st == odl_pkg::DEV_BIT)
    && r_reg.nbits != 5'h00 && line_s && r_reg.high_cnt >= TIMEOUT_C;

  always_comb
  begin
    r_next = r_reg;
    r_next.ok_p = 1'b0;
    r_next.err_p = 1'b0;
    r_next.prev = line_s;
    if (line_s)
    begin
      r_next.high_cnt = sat_inc(r_reg.high_cnt);
    end
    else
    begin
      r_next.low_cnt = sat_inc(r_reg.low_cnt);
    end
    case (r_reg.st)
      odl_pkg::DEV_GAP:
      begin
        if (rise && r_reg.nbits == odl_pkg::BYTE_BITS && r_reg.low_cnt < EOS_C)
        begin
          r_next.bad = 1'b1;
        end
        if (fall)
        begin
          r_next.st = odl_pkg::DEV_BIT;
          r_next.low_cnt = ONE_C;
          r_next.high_cnt = '0;
          if (r_reg.nbits == 5'h00)
          begin
            r_next.bad = 1'b0;
          end
        end
      end
      odl_pkg::DEV_BIT:
      begin
        if (fall)
        begin
          r_next.low_cnt = ONE_C;
          r_next.high_cnt = '0;
          r_next.shreg = {r_reg.shreg[14:0], dec[0]};
          r_next.bad = r_reg.bad | ~dec[1];
          r_next.nbits = r_reg.nbits + 5'h01;
          if (r_next.nbits == odl_pkg::BYTE_BITS)
          begin
            r_next.st = odl_pkg::DEV_GAP;
          end
          else if (r_next.nbits == odl_pkg::FRAME_BITS)
          begin
            r_next.st = odl_pkg::DEV_VAL;
            r_next.tmr = '0;
          end
        end
      end
      odl_pkg::DEV_VAL:
      begin
        r_next.tmr = r_reg.tmr + 1'b1;
        if (rise)
        begin
          // Line released before the validation delay was complete.
          r_next.err_p = 1'b1;
          r_next.st = odl_pkg::DEV_GAP;
          r_next.nbits = 5'h00;
        end
        else if (r_reg.tmr == VALACK_LAST)
        begin
          r_next.nbits = 5'h00;
          r_next.st = odl_pkg::DEV_GAP;
          if (good)
          begin
            r_next.level = r_reg.shreg[odl_pkg::LEVEL_MSB:0];
            r_next.mv = MV_TABLE[r_reg.shreg[odl_pkg::LEVEL_MSB:0]];
            r_next.ok_p = 1'b1;
            if (r_reg.shreg[odl_pkg::ACK_REQ_POS])
            begin
              r_next.st = odl_pkg::DEV_ACK;
              r_next.pull = 1'b1;
              r_next.tmr = '0;
            end
          end
          else
          begin
            r_next.err_p = 1'b1;
          end
        end
      end
      odl_pkg::DEV_ACK:
      begin
        r_next.tmr = r_reg.tmr + 1'b1;
        if (r_reg.tmr == ACK_LAST)
        begin
          r_next.pull = 1'b0;
          r_next.st = odl_pkg::DEV_GAP;
        end
      end
      default:
      begin
        r_next.st = odl_pkg::DEV_GAP;
        r_next.nbits = 5'h00;
        r_next.pull = 1'b0;
      end
    endcase
    if (abort)
    begin
      r_next.st = odl_pkg::DEV_GAP;
      r_next.nbits = 5'h00;
      r_next.err_p = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '{
        st: odl_pkg::DEV_GAP,
        prev: 1'b1,
        low_cnt: '0,
        high_cnt: '0,
        nbits: 5'h00,
        shreg: 16'h0000,
        bad: 1'b0,
        tmr: '0,
        level: odl_pkg::LEVEL_RESET,
        mv: MV_TABLE[odl_pkg::LEVEL_RESET],
        ok_p: 1'b0,
        err_p: 1'b0,
        pull: 1'b0
      };
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Open drain: the driven value is always low, only the enable moves.
  assign link.dev_o = 1'b0;
  assign link.dev_oe = r_reg.pull;
  assign level_code = r_reg.level;
  assign fb_ref_mv = r_reg.mv;
  assign frame_ok = r_reg.ok_p;
  assign frame_err = r_reg.err_p;
  assign ack_active = r_reg.pull;
endmodule // odl_device

// file: verilog/odl_pkg.sv
// Constants, timing counts and state encodings for the one-wire dimming link.
package odl_pkg;
  localparam int CLK_MHZ = 200;
  localparam int T_START_US = 2;
  localparam int END_OF_STREAM_TIME_US = 2;
  localparam int ACK_VALIDATION_DELAY_US = 2;
  localparam int T_ACK_US = 512;
  localparam int T_TIMEOUT_US = 1000;
  localparam int T_UNIT_US = 2;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int EOS_CYC = END_OF_STREAM_TIME_US * CLK_MHZ;
  localparam int VALACK_CYC = ACK_VALIDATION_DELAY_US * CLK_MHZ;
  localparam int ACK_CYC = T_ACK_US * CLK_MHZ;
  localparam int TIMEOUT_CYC = T_TIMEOUT_US * CLK_MHZ;
  localparam int UNIT_CYC = T_UNIT_US * CLK_MHZ;
  localparam int SENSE_CYC = 4;
  localparam int MARGIN_CYC = 8;
  localparam int RATIO_LONG = 3;
  localparam int MIN_BIT_CYC = 1250;
  localparam int MAX_BIT_CYC = 117647;
  localparam logic [4:0] LEVEL_RESET = 5'h1f;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int ACK_REQ_POS = 7;
  localparam int SUB_HI_POS = 6;
  localparam int SUB_LO_POS = 5;
  localparam int LEVEL_MSB = 4;
  // Arbitrary device address value.
  localparam logic [7:0] DEV_ADDR_DEF = 8'h5a;
  localparam logic [1:0] SUB_ADDR_DEF = 2'h0;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int GO_POS = 0;
  localparam int ADDR_LSB = 8;
  localparam int DATA_LSB = 16;
  localparam int BUSY_POS = 0;
  localparam int ACK_SEEN_POS = 1;
  localparam int DONE_POS = 2;
  localparam int ACK_REQ_SENT_POS = 3;
  typedef enum logic [3:0] {
    DEV_GAP = 4'b0001,
    DEV_BIT = 4'b0010,
    DEV_VAL = 4'b0100,
    DEV_ACK = 4'b1000
  } odl_dev_state_t;
  typedef enum logic [6:0] {
    HST_IDLE = 7'b0000001,
    HST_START = 7'b0000010,
    HST_LOW = 7'b0000100,
    HST_HIGH = 7'b0001000,
    HST_EOS = 7'b0010000,
    HST_SENSE = 7'b0100000,
    HST_DRAIN = 7'b1000000
  } odl_hst_state_t;
endpackage

// file: verilog/odl_link_if.sv
// Dimming line carrier joining the host end and the device end.
`timescale 1ns/10ps
interface odl_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic dim_line;
  // The host supplies the pull-up, so the line is high unless someone drives it low.
  assign dim_line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));
  modport dev(input dim_line, output dev_o, output dev_oe);
  modport host(input dim_line, output host_o, output host_oe);
endinterface

// file: verilog/odl_sync.sv
// Two-stage synchroniser for the dimming line.
`timescale 1ns/10ps
module odl_sync #(
  parameter logic RST_VAL = 1'b1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } odl_sync_regs_t;
  odl_sync_regs_t r_reg;
  odl_sync_regs_t r_next;

  always_comb
  begin
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '{s1: RST_VAL, s2: RST_VAL};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule // odl_sync

// file: verilog/odl_host.sv
// Host end of the one-wire dimming link, ordered over APB.
`timescale 1ns/10ps
module odl_host #(
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int TMR_W = 17,
  parameter int UNIT_CYC = odl_pkg::UNIT_CYC,
  parameter int START_CYC = odl_pkg::START_CYC,
  parameter int EOS_CYC = odl_pkg::EOS_CYC,
  parameter int VALACK_CYC = odl_pkg::VALACK_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  odl_link_if.host link
);
  localparam logic [TMR_W-1:0] SHORT_LAST = TMR_W'(UNIT_CYC - 1);
  localparam logic [TMR_W-1:0] LONG_LAST = TMR_W'(odl_pkg::RATIO_LONG * UNIT_CYC - 1);
  localparam logic [TMR_W-1:0] START_LAST = TMR_W'(START_CYC - 1);
  localparam logic [TMR_W-1:0] EOS_LAST = TMR_W'(EOS_CYC - 1);
  localparam logic [TMR_W-1:0] FINAL_LAST = TMR_W'(VALACK_CYC + odl_pkg::MARGIN_CYC - 1);
  localparam logic [TMR_W-1:0] SENSE_LAST = TMR_W'(odl_pkg::SENSE_CYC - 1);

  generate
    if (4 * UNIT_CYC < odl_pkg::MIN_BIT_CYC || 4 * UNIT_CYC > odl_pkg::MAX_BIT_CYC
      || odl_pkg::RATIO_LONG * UNIT_CYC >= (1 << TMR_W))
    begin : g_bad_unit
      $error("odl_host: bit unit outside the supported bit rate range");
    end
  endgenerate

  typedef struct packed {
    odl_pkg::odl_hst_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [2:0] bitidx;
    logic second;
    logic [7:0] addr;
    logic [7:0] data;
    logic drive_low;
    logic busy;
    logic ack_seen;
    logic done;
    logic [31:0] rdata;
  } odl_hst_regs_t;

  odl_hst_regs_t r_reg;
  odl_hst_regs_t r_next;
  logic line_s;
  logic cur_bit;
  logic [31:0] status_word;

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  odl_sync #(
    .RST_VAL(1'b1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.dim_line),
    .q(line_s)
  );

  assign cur_bit = r_reg.second ? r_reg.data[r_reg.bitidx] : r_reg.addr[r_reg.bitidx];
  assign status_word = {28'h0000000, r_reg.data[odl_pkg::ACK_REQ_POS], r_reg.done, r_reg.ack_seen, r_reg.busy};

  always_comb
  begin
    r_next = r_reg;
    if (psel && !penable && !pwrite)
    begin
      r_next.rdata = reg_hit(paddr, odl_pkg::STATUS_OFS) ? status_word : 32'h00000000;
    end
    r_next.tmr = r_reg.tmr + 1'b1;
    case (r_reg.st)
      odl_pkg::HST_IDLE:
      begin
        r_next.tmr = '0;
        r_next.drive_low = 1'b0;
        if (psel && penable && pwrite && reg_hit(paddr, odl_pkg::CTRL_OFS) && pwdata[odl_pkg::GO_POS])
        begin
          r_next.addr = pwdata[odl_pkg::ADDR_LSB +: 8];
          r_next.data = pwdata[odl_pkg::DATA_LSB +: 8];
          // A push-pull stage must never ask for the acknowledge.
          r_next.data[odl_pkg::ACK_REQ_POS] = pwdata[odl_pkg::DATA_LSB + odl_pkg::ACK_REQ_POS] & OPEN_DRAIN;
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.ack_seen = 1'b0;
          r_next.second = 1'b0;
          r_next.bitidx = 3'h7;
          r_next.st = line_s ? odl_pkg::HST_LOW : odl_pkg::HST_START;
          r_next.drive_low = line_s;
        end
      end
      odl_pkg::HST_START:
      begin
        if (r_reg.tmr == START_LAST)
        begin
          r_next.tmr = '0;
          r_next.st = odl_pkg::HST_LOW;
          r_next.drive_low = 1'b1;
        end
      end
      odl_pkg::HST_LOW:
      begin
        if (r_reg.tmr == (cur_bit ? SHORT_LAST : LONG_LAST))
        begin
          r_next.tmr = '0;
          r_next.st = odl_pkg::HST_HIGH;
          r_next.drive_low = 1'b0;
        end
      end
      odl_pkg::HST_HIGH:
      begin
        if (r_reg.tmr == (cur_bit ? LONG_LAST : SHORT_LAST))
        begin
          r_next.tmr = '0;
          r_next.drive_low = 1'b1;
          r_next.bitidx = r_reg.bitidx - 3'h1;
          r_next.st = (r_reg.bitidx == 3'h0) ? odl_pkg::HST_EOS : odl_pkg::HST_LOW;
        end
      end
      odl_pkg::HST_EOS:
      begin
        // The last byte stays low through validation so the device pull-down takes over cleanly.
        if (r_reg.tmr == (r_reg.second ? FINAL_LAST : EOS_LAST))
        begin
          r_next.tmr = '0;
          r_next.drive_low = 1'b0;
          if (!r_reg.second)
          begin
            r_next.second = 1'b1;
            r_next.bitidx = 3'h7;
            r_next.st = odl_pkg::HST_START;
          end
          else
          begin
            r_next.st = r_reg.data[odl_pkg::ACK_REQ_POS] ? odl_pkg::HST_SENSE : odl_pkg::HST_DRAIN;
          end
        end
      end
      odl_pkg::HST_SENSE:
      begin
        if (r_reg.tmr == SENSE_LAST)
        begin
          r_next.ack_seen = ~line_s;
          r_next.st = odl_pkg::HST_DRAIN;
        end
      end
      odl_pkg::HST_DRAIN:
      begin
        if (line_s)
        begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.st = odl_pkg::HST_IDLE;
        end
      end
      default:
      begin
        r_next.st = odl_pkg::HST_IDLE;
        r_next.drive_low = 1'b0;
        r_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '{
        st: odl_pkg::HST_IDLE,
        tmr: '0,
        bitidx: 3'h7,
        second: 1'b0,
        addr: 8'h00,
        data: 8'h00,
        drive_low: 1'b0,
        busy: 1'b0,
        ack_seen: 1'b0,
        done: 1'b0,
        rdata: 32'h00000000
      };
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Open drain releases the line; push-pull drives it high, which needs a series resistor.
  assign link.host_o = OPEN_DRAIN ? 1'b0 : ~r_reg.drive_low;
  assign link.host_oe = OPEN_DRAIN ? r_reg.drive_low : 1'b1;
  assign prdata = r_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(reg_hit(paddr, odl_pkg::CTRL_OFS) | reg_hit(paddr, odl_pkg::STATUS_OFS));
endmodule // odl_host

// file: sim/odl_checker.sv
// Concurrent checks on the dimming line between the host end and the device end.
`timescale 1ns/10ps
module odl_checker #(
  parameter int UNIT_CYC = 400,
  parameter int EOS_CYC = 400,
  parameter int VALACK_CYC = 400,
  parameter int ACK_CYC = 102400
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic dim_line
);
  int low_cnt;
  int ack_len;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The low counter saturates so that a line held low for long never wraps into a false match.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt <= 0;
      ack_len <= 0;
    end
    else
    begin
      low_cnt <= dim_line ? 0 : ((low_cnt < 1000000) ? low_cnt + 1 : low_cnt);
      ack_len <= dev_oe ? ack_len + 1 : 0;
    end
  end
  sequence ack_start;
    $rose(dev_oe);
  endsequence
  sequence host_rise;
    $rose(dim_line) && !$past(dev_oe);
  endsequence
  dev_val_zero_a: assert property (dev_oe |-> !dev_o)
    else $error("device drives the line high");
  host_od_a: assert property (host_oe |-> !host_o)
    else $error("host drives the line high");
  ack_pulls_line_a: assert property (dev_oe |-> !dim_line)
    else $error("line high while device pulls down");
  ack_after_val_a: assert property (ack_start |-> low_cnt inside {[VALACK_CYC:VALACK_CYC + 8]})
    else $error("acknowledge not after validation delay");
  ack_hold_a: assert property (ack_start |-> dev_oe [*8])
    else $error("acknowledge pulse too short");
  ack_len_exact_a: assert property ($fell(dev_oe) |-> ack_len == ACK_CYC)
    else $error("acknowledge pulse length wrong");
  ack_bounded_a: assert property (ack_len <= ACK_CYC)
    else $error("acknowledge pulse too long");
  host_release_a: assert property (ack_start |-> ##[0:16] !host_oe)
    else $error("host did not release for acknowledge");
  host_quiet_a: assert property ($fell(dev_oe) |-> !host_oe)
    else $error("host drove line during acknowledge");
  low_widths_a: assert property (host_rise |-> low_cnt inside {[UNIT_CYC - 1:UNIT_CYC + 1],
    [3 * UNIT_CYC - 1:3 * UNIT_CYC + 1], [EOS_CYC - 1:EOS_CYC + 1], [VALACK_CYC + 7:VALACK_CYC + 9]})
    else $error("host low time off the bit coding");
  reset_idle_a: assert property ($rose(presetn) |-> !dev_oe && !host_oe)
    else $error("line driven right after reset");
endmodule // odl_checker

// file: sim/testbench.sv
// Self-checking bench joining the host and device ends of the dimming link.
`timescale 1ns/10ps
module testbench;
  localparam int UNIT = 320;
  localparam int SHORT = 100;
  localparam int ACKL = 200;
  localparam logic [7:0] FB_TAB [32] = '{8'h00, 8'h05, 8'h08, 8'h0b, 8'h0e, 8'h11, 8'h14, 8'h17, 8'h1a, 8'h1d,
    8'h20, 8'h23, 8'h26, 8'h2c, 8'h32, 8'h38, 8'h3e, 8'h44, 8'h4a, 8'h50, 8'h56, 8'h5c, 8'h62, 8'h68, 8'h74,
    8'h80, 8'h8c, 8'h98, 8'ha4, 8'hb0, 8'hbc, 8'hc8};
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] level_code;
  logic [7:0] fb_ref_mv;
  logic frame_ok;
  logic frame_err;
  logic ack_active;
  logic [4:0] exp_level;
  logic [31:0] seed;
  logic [31:0] rd;
  logic er;
  logic [15:0] wire_bits = 16'h0000;
  logic line_q = 1'b1;
  int fail_count = 0;
  int checked = 0;
  int ok_n = 0;
  int err_n = 0;
  int lo_n = 0;
  int hi_n = 0;
  int wire_n = 0;
  int ack_n = 0;
  odl_link_if link();
  odl_host #(.UNIT_CYC(UNIT), .START_CYC(SHORT), .EOS_CYC(SHORT), .VALACK_CYC(SHORT)) i_odl_host (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  odl_device #(.ACK_CYC(ACKL), .TIMEOUT_CYC(2000), .VALACK_CYC(SHORT), .EOS_CYC(SHORT)) i_odl_device (.pclk(pclk),
    .presetn(presetn), .link(link), .level_code(level_code), .fb_ref_mv(fb_ref_mv), .frame_ok(frame_ok),
    .frame_err(frame_err), .ack_active(ack_active));
  odl_checker #(.UNIT_CYC(UNIT), .EOS_CYC(SHORT), .VALACK_CYC(SHORT), .ACK_CYC(ACKL)) i_odl_checker (.pclk(pclk),
    .presetn(presetn), .host_o(link.host_o), .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe),
    .dim_line(link.dim_line));
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Bits are decoded on the wire itself; long idle stretches are not counted as bits.
  always @(posedge pclk)
  begin
    line_q <= link.dim_line;
    if (frame_ok === 1'b1) ok_n <= ok_n + 1;
    if (frame_err === 1'b1) err_n <= err_n + 1;
    if (ack_active === 1'b1) ack_n <= ack_n + 1;
    if (line_q === 1'b1 && link.dim_line === 1'b0)
    begin
      if (lo_n > 0 && lo_n + hi_n < 5 * UNIT && hi_n >= 2 * lo_n)
      begin
        wire_bits <= {wire_bits[14:0], 1'b1};
        wire_n <= wire_n + 1;
      end
      else if (hi_n > 0 && lo_n + hi_n < 5 * UNIT && lo_n >= 2 * hi_n)
      begin
        wire_bits <= {wire_bits[14:0], 1'b0};
        wire_n <= wire_n + 1;
      end
      lo_n <= 1;
      hi_n <= 0;
    end
    else if (link.dim_line === 1'b0) lo_n <= lo_n + 1;
    else hi_n <= hi_n + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] fb_mv(input logic [4:0] c);
    return FB_TAB[c];
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 100)
    begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic run_cmd(input logic [7:0] a, input logic [7:0] d, input logic good);
    int w0;
    int o0;
    int e0;
    int a0;
    int n;
    w0 = wire_n;
    o0 = ok_n;
    e0 = err_n;
    a0 = ack_n;
    apb(1'b1, odl_pkg::CTRL_OFS, {8'h00, d, a, 8'h01});
    for (n = 0; n < 20000; n++)
    begin
      apb(1'b0, odl_pkg::STATUS_OFS, 32'h0000_0000);
      if (rd[odl_pkg::DONE_POS] === 1'b1) break;
    end
    if (n == 20000)
    begin
      fail_count++;
      close_out();
    end
    // The idle gap keeps the next command's first edge from pairing with this frame's tail.
    repeat (5 * UNIT) @(posedge pclk);
    chk("wire bit count", 32'd16, wire_n - w0);
    chk("wire bits", {16'h0000, a, d}, {16'h0000, wire_bits});
    chk("frames stored", {31'h0, good}, ok_n - o0);
    chk("frames discarded", {31'h0, !good}, err_n - e0);
    if (good) exp_level = d[4:0];
    chk("level code", {27'h0, exp_level}, {27'h0, level_code});
    chk("feedback mv", {24'h0, fb_mv(exp_level)}, {24'h0, fb_ref_mv});
    chk("ack seen", {31'h0, good & d[7]}, {31'h0, rd[odl_pkg::ACK_SEEN_POS]});
    chk("ack requested", {31'h0, d[7]}, {31'h0, rd[odl_pkg::ACK_REQ_SENT_POS]});
    chk("ack pulse cycles", (good & d[7]) ? 32'(ACKL) : 32'h0, ack_n - a0);
    $display("test done: address %h data %h", a, d);
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    seed = 32'h66d463e3;
    exp_level = odl_pkg::LEVEL_RESET;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset level", 32'h1f, {27'h0, level_code});
    chk("reset mv", 32'hc8, {24'h0, fb_ref_mv});
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test done: register access");
    run_cmd(odl_pkg::DEV_ADDR_DEF, 8'h80, 1'b1);
    seed = xs(seed);
    run_cmd(odl_pkg::DEV_ADDR_DEF, {3'b000, seed[4:0]}, 1'b1);
    seed = xs(seed);
    run_cmd(odl_pkg::DEV_ADDR_DEF ^ (seed[7:0] | 8'h01), {3'b100, seed[12:8]}, 1'b0);
    run_cmd(odl_pkg::DEV_ADDR_DEF, {3'b101, seed[20:16]}, 1'b0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("level after reset", 32'h1f, {27'h0, level_code});
    $display("test done: second reset");
    close_out();
  end
endmodule // testbench
